//--- core/urxf_consts.vh
// Shared constants for the receive endpoint flow logic
`ifndef URXF_CONSTS_VH
`define URXF_CONSTS_VH

// ****************************************
// Status flag positions
// ****************************************
`define URXF_NFLAGS 7
`define URXF_F_ERR 0
`define URXF_F_ACK 1
`define URXF_F_VOID 2
`define URXF_F_SETUP 3
`define URXF_F_OVF 4
`define URXF_F_URF 5
`define URXF_F_OVWEND 6
`define URXF_FLAGS_RST 7'h00

// ****************************************
// Handshake codes
// ****************************************
`define URXF_HS_ACK 2'h0
`define URXF_HS_NAK 2'h1
`define URXF_HS_STALL 2'h2

// ****************************************
// Fill state operations and values
// ****************************************
`define URXF_FOP_NONE 2'h0
`define URXF_FOP_INC 2'h1
`define URXF_FOP_SETRST 2'h2
`define URXF_FOP_CLEAR 2'h3
`define URXF_FILL_EMPTY 2'h0
`define URXF_FILL_ONE 2'h1
`define URXF_FILL_FULL 2'h3

`endif

//--- core/urxf_flag.v
// One sticky status flag: hardware load wins over firmware clear
module urxf_flag (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Hardware load
   input wire hw_we,
   input wire hw_val,
   // Firmware clear
   input wire fw_clr,
   // Flag
   output reg flag_q
);

   reg flag_d;

   always @* begin
      flag_d = flag_q;
      if (hw_we) begin
         flag_d = hw_val;
      end else if (fw_clr) begin
         flag_d = 1'b0;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

endmodule // urxf_flag

//--- core/urxf_fill.v
// Packet fill state of the two receive buffers
`include "urxf_consts.vh"

module urxf_fill (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Mode
   input wire single_mode,
   // Bus side operation
   input wire op_valid,
   input wire [1:0] op,
   // Firmware read complete
   input wire dec,
   // Fill state
   output wire [1:0] fill_state
);

   reg [1:0] valid_q;
   reg [1:0] valid_d;
   reg wr_q;
   reg wr_d;
   reg rd_q;
   reg rd_d;

   assign fill_state = valid_q;

   always @* begin
      valid_d = valid_q;
      wr_d = wr_q;
      rd_d = rd_q;
      // Firmware step down acts immediately
      if (dec && (valid_d != `URXF_FILL_EMPTY)) begin
         if (single_mode) begin
            valid_d = `URXF_FILL_EMPTY;
         end else begin
            valid_d[rd_d] = 1'b0;
            rd_d = ~rd_d;
         end
      end
      if (op_valid) begin
         case (op)
            `URXF_FOP_INC: begin
               if (single_mode) begin
                  valid_d[0] = 1'b1;
               end else begin
                  valid_d[wr_d] = 1'b1;
                  wr_d = ~wr_d;
               end
            end
            `URXF_FOP_SETRST: begin
               valid_d = `URXF_FILL_ONE;
               wr_d = ~single_mode;
               rd_d = 1'b0;
            end
            `URXF_FOP_CLEAR: begin
               valid_d = `URXF_FILL_EMPTY;
               wr_d = 1'b0;
               rd_d = 1'b0;
            end
            default: begin
               valid_d = valid_d;
            end
         endcase
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         valid_q <= `URXF_FILL_EMPTY;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end else begin
         valid_q <= valid_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end

endmodule // urxf_fill

//--- core/urxf_flow.v
// Receive endpoint flow control: token decisions, handshakes and status flags
`include "urxf_consts.vh"

module urxf_flow (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Configuration
   input wire rcv_endpoint_enable,
   input wire auto_rcv_manage,
   input wire single_packet_select,
   input wire rcv_input_enable,
   input wire rcv_stall,
   input wire ctrl_endpoint,
   // Serial engine events
   input wire out_token,
   input wire setup_token,
   input wire data_good,
   input wire data_crc_err,
   input wire data_timeout,
   input wire fifo_overrun,
   input wire toggle_mismatch,
   input wire hs_done,
   // Handshake request
   output reg hs_valid_q,
   output reg [1:0] hs_code_q,
   // Byte FIFO pointer control
   output reg wr_advance_q,
   output reg wr_rewind_q,
   output reg fifo_reset_q,
   // CPU side
   input wire cpu_read_underrun,
   input wire rcv_read_complete,
   input wire [6:0] flag_clear,
   // Status
   output wire rcv_error_flag,
   output wire rcv_acked_flag,
   output wire rcv_void_flag,
   output wire setup_received_flag,
   output wire rcv_overrun_flag,
   output wire rcv_underrun_flag,
   output wire setup_overwrite_end,
   output reg setup_overwrite_start_q,
   output wire [1:0] rcv_fill_state,
   output reg rcv_irq_q
);

   // ****************************************
   // States
   // ****************************************
   localparam ST_IDLE = 4'h1;
   localparam ST_DATA = 4'h2;
   localparam ST_HAND = 4'h4;
   localparam ST_COMMIT = 4'h8;

   reg [3:0] st_q;
   reg [3:0] st_d;
   reg setup_q;
   reg nak_q;
   reg stall_q;
   reg [6:0] pend_we_q;
   reg [6:0] pend_val_q;
   reg [1:0] pend_fop_q;
   reg pend_irq_q;

   reg [6:0] nx_we;
   reg [6:0] nx_val;
   reg [1:0] nx_fop;
   reg nx_irq;
   reg nx_hs;
   reg [1:0] nx_code;
   reg nx_rew;
   reg nx_adv;

   wire [6:0] flags;
   wire [6:0] hw_we;
   wire [6:0] hw_val;
   wire active;
   wire fifo_err;
   wire fill_full;
   wire end_evt;
   wire take_token;
   wire commit;

   assign rcv_error_flag = flags[`URXF_F_ERR];
   assign rcv_acked_flag = flags[`URXF_F_ACK];
   assign rcv_void_flag = flags[`URXF_F_VOID];
   assign setup_received_flag = flags[`URXF_F_SETUP];
   assign rcv_overrun_flag = flags[`URXF_F_OVF];
   assign rcv_underrun_flag = flags[`URXF_F_URF];
   assign setup_overwrite_end = flags[`URXF_F_OVWEND];

   // ****************************************
   // Token acceptance
   // ****************************************
   assign active = rcv_endpoint_enable & auto_rcv_manage;
   assign fifo_err = rcv_overrun_flag | rcv_underrun_flag;
   assign fill_full = single_packet_select ? (rcv_fill_state != `URXF_FILL_EMPTY) :
                      (rcv_fill_state == `URXF_FILL_FULL);
   assign take_token = active & (st_q == ST_IDLE) & (out_token | setup_token);
   assign end_evt = data_good | data_crc_err | data_timeout | fifo_overrun;
   assign commit = (st_q == ST_COMMIT) | ((st_q == ST_HAND) & hs_done);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         setup_q <= 1'b0;
         nak_q <= 1'b0;
         stall_q <= 1'b0;
      end else if (take_token) begin
         // SETUP ignores input enable, stall and FIFO errors
         setup_q <= setup_token;
         nak_q <= ~setup_token & (fifo_err | (~rcv_stall & (~rcv_input_enable | fill_full)));
         stall_q <= ~setup_token & ~fifo_err & rcv_stall;
      end
   end

   // ****************************************
   // Transaction outcome
   // ****************************************
   always @* begin
      nx_we = 7'h00;
      nx_val = 7'h00;
      nx_fop = `URXF_FOP_NONE;
      nx_irq = 1'b0;
      nx_hs = 1'b0;
      nx_code = `URXF_HS_ACK;
      nx_rew = 1'b0;
      nx_adv = 1'b0;
      if (setup_q) begin
         nx_irq = 1'b1;
         nx_we[`URXF_F_ERR] = 1'b1;
         nx_we[`URXF_F_ACK] = 1'b1;
         nx_we[`URXF_F_VOID] = 1'b1;
         nx_we[`URXF_F_OVF] = 1'b1;
         nx_we[`URXF_F_URF] = 1'b1;
         nx_we[`URXF_F_SETUP] = ctrl_endpoint;
         if (fifo_overrun) begin
            nx_val[`URXF_F_ERR] = 1'b1;
            nx_val[`URXF_F_SETUP] = 1'b1;
            nx_val[`URXF_F_OVF] = 1'b1;
            nx_fop = `URXF_FOP_CLEAR;
            nx_rew = 1'b1;
         end else if (data_crc_err) begin
            nx_val[`URXF_F_ERR] = 1'b1;
            nx_val[`URXF_F_SETUP] = 1'b1;
            nx_fop = `URXF_FOP_CLEAR;
            nx_rew = 1'b1;
         end else if (data_timeout) begin
            nx_val[`URXF_F_ERR] = 1'b1;
            nx_rew = 1'b1;
         end else begin
            nx_val[`URXF_F_ACK] = 1'b1;
            nx_val[`URXF_F_SETUP] = 1'b1;
            nx_fop = `URXF_FOP_SETRST;
            nx_hs = 1'b1;
            nx_adv = 1'b1;
         end
      end else if (nak_q) begin
         // Void transaction: data ignored, only the void flag moves
         nx_we[`URXF_F_VOID] = 1'b1;
         nx_val[`URXF_F_VOID] = 1'b1;
         nx_hs = ~data_timeout;
         nx_code = `URXF_HS_NAK;
         nx_rew = 1'b1;
      end else if (stall_q) begin
         nx_hs = ~data_timeout;
         nx_code = `URXF_HS_STALL;
         nx_rew = 1'b1;
      end else if (fifo_overrun) begin
         nx_irq = 1'b1;
         nx_we[`URXF_F_ERR] = 1'b1;
         nx_we[`URXF_F_ACK] = 1'b1;
         nx_we[`URXF_F_VOID] = 1'b1;
         nx_we[`URXF_F_SETUP] = 1'b1;
         nx_we[`URXF_F_OVF] = 1'b1;
         nx_val[`URXF_F_ERR] = 1'b1;
         nx_val[`URXF_F_OVF] = 1'b1;
         nx_rew = 1'b1;
      end else if (data_crc_err) begin
         nx_irq = 1'b1;
         nx_we[`URXF_F_ERR] = 1'b1;
         nx_we[`URXF_F_ACK] = 1'b1;
         nx_we[`URXF_F_VOID] = 1'b1;
         nx_we[`URXF_F_SETUP] = 1'b1;
         nx_val[`URXF_F_ERR] = 1'b1;
         nx_rew = 1'b1;
      end else if (data_timeout) begin
         nx_we[`URXF_F_VOID] = 1'b1;
         nx_val[`URXF_F_VOID] = 1'b1;
         nx_rew = 1'b1;
      end else if (toggle_mismatch) begin
         // Repeated packet: acknowledge again, drop the data
         nx_hs = 1'b1;
         nx_rew = 1'b1;
      end else begin
         nx_irq = 1'b1;
         nx_we[`URXF_F_ERR] = 1'b1;
         nx_we[`URXF_F_ACK] = 1'b1;
         nx_we[`URXF_F_VOID] = 1'b1;
         nx_we[`URXF_F_SETUP] = 1'b1;
         nx_val[`URXF_F_ACK] = 1'b1;
         nx_fop = `URXF_FOP_INC;
         nx_hs = 1'b1;
         nx_adv = 1'b1;
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always @* begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (take_token) begin
               st_d = ST_DATA;
            end
         end
         ST_DATA: begin
            if (end_evt) begin
               st_d = nx_hs ? ST_HAND : ST_COMMIT;
            end
         end
         ST_HAND: begin
            if (hs_done) begin
               st_d = ST_IDLE;
            end
         end
         ST_COMMIT: begin
            st_d = ST_IDLE;
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // Outcome held until the handshake phase ends, or until ST_COMMIT when no handshake is sent
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_we_q <= 7'h00;
         pend_val_q <= 7'h00;
         pend_fop_q <= `URXF_FOP_NONE;
         pend_irq_q <= 1'b0;
      end else if ((st_q == ST_DATA) && end_evt) begin
         pend_we_q <= nx_we;
         pend_val_q <= nx_val;
         pend_fop_q <= nx_fop;
         pend_irq_q <= nx_irq;
      end
   end

   // ****************************************
   // Handshake and pointer strobes
   // ****************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hs_valid_q <= 1'b0;
         hs_code_q <= `URXF_HS_ACK;
         wr_advance_q <= 1'b0;
         wr_rewind_q <= 1'b0;
         fifo_reset_q <= 1'b0;
         rcv_irq_q <= 1'b0;
      end else begin
         hs_valid_q <= (st_q == ST_DATA) & end_evt & nx_hs;
         if ((st_q == ST_DATA) && end_evt) begin
            hs_code_q <= nx_code;
         end
         wr_advance_q <= (st_q == ST_DATA) & end_evt & nx_adv;
         wr_rewind_q <= (st_q == ST_DATA) & end_evt & nx_rew;
         fifo_reset_q <= take_token & setup_token;
         rcv_irq_q <= commit & pend_irq_q;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         setup_overwrite_start_q <= 1'b0;
      end else if (take_token && setup_token) begin
         setup_overwrite_start_q <= 1'b1;
      end else if (((st_q == ST_DATA) && end_evt && nx_hs) || commit) begin
         setup_overwrite_start_q <= 1'b0;
      end
   end

   // ****************************************
   // Status flags
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < `URXF_NFLAGS; gi = gi + 1) begin : g_flag
         if (gi == `URXF_F_URF) begin : g_urf
            // Underrun comes from the CPU side and sets at once
            assign hw_we[gi] = cpu_read_underrun | (commit & pend_we_q[gi]);
            assign hw_val[gi] = cpu_read_underrun | pend_val_q[gi];
         end else if (gi == `URXF_F_OVWEND) begin : g_ovw
            assign hw_we[gi] = (st_q == ST_DATA) & end_evt & nx_hs & setup_q;
            assign hw_val[gi] = 1'b1;
         end else begin : g_bus
            assign hw_we[gi] = commit & pend_we_q[gi];
            assign hw_val[gi] = pend_val_q[gi];
         end
         urxf_flag u_flag (
            .clk(clk),
            .rst_n(rst_n),
            .hw_we(hw_we[gi]),
            .hw_val(hw_val[gi]),
            .fw_clr(flag_clear[gi]),
            .flag_q(flags[gi])
         );
      end
   endgenerate

   // ****************************************
   // Fill state
   // ****************************************
   urxf_fill u_fill (
      .clk(clk),
      .rst_n(rst_n),
      .single_mode(single_packet_select),
      .op_valid(commit),
      .op(pend_fop_q),
      .dec(rcv_read_complete),
      .fill_state(rcv_fill_state)
   );

endmodule // urxf_flow

//--- bench/urxf_flow_checker.sv
// Assertion checker for the receive endpoint flow control ports
`include "urxf_consts.vh"
module urxf_flow_checker (
   // Clock, reset and configuration
   input wire logic clk, rst_n, rcv_endpoint_enable, auto_rcv_manage,
   input wire logic single_packet_select, rcv_input_enable, rcv_stall,
   // Serial engine side
   input wire logic out_token, setup_token, data_good, data_crc_err,
   input wire logic data_timeout, fifo_overrun, hs_done, hs_valid_q, fifo_reset_q,
   input wire logic [1:0] hs_code_q,
   input wire logic wr_advance_q, wr_rewind_q,
   // Firmware side and status
   input wire logic cpu_read_underrun, rcv_read_complete, rcv_error_flag, rcv_acked_flag,
   input wire logic rcv_void_flag, rcv_overrun_flag, rcv_underrun_flag, rcv_irq_q,
   input wire logic setup_overwrite_end, setup_overwrite_start_q,
   input wire logic [6:0] flag_clear,
   input wire logic [1:0] rcv_fill_state
);
   logic open_q, kind_q, end_q;
   wire en = rcv_endpoint_enable & auto_rcv_manage;
   wire acc = (out_token | setup_token) & en & ~open_q;
   wire bad = data_crc_err | data_timeout | fifo_overrun;
   wire room = single_packet_select ? (rcv_fill_state == 2'h0) : (rcv_fill_state != 2'h3);
   wire ferr = rcv_overrun_flag | rcv_underrun_flag;
   wire good_out = open_q & ~kind_q & data_good & ~bad & ~rcv_stall;
   wire quiet = ~hs_done & ~end_q & ~open_q;

   // ****************************************
   // Transaction tracking
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         open_q <= 1'b0;
         kind_q <= 1'b0;
         end_q <= 1'b0;
      end else begin
         open_q <= acc | (open_q & ~(bad | data_good));
         if (acc) kind_q <= setup_token;
         end_q <= open_q & (bad | data_good);
      end
   end

   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_flush;
      fifo_reset_q && setup_overwrite_start_q;
   endsequence
   sequence s_hs(code);
      hs_valid_q && hs_code_q == code;
   endsequence
   property p_setup_flush;
      acc && setup_token |=> s_flush;
   endproperty
   a_setup_flush: assert property (p_setup_flush) else $error("setup did not flush");
   property p_setup_ack;
      open_q && kind_q && data_good && !bad |=> s_hs(`URXF_HS_ACK)
         and (setup_overwrite_end && !setup_overwrite_start_q);
   endproperty
   a_setup_ack: assert property (p_setup_ack) else $error("setup not acked");
   property p_out_ack;
      good_out && rcv_input_enable && !ferr && room |=> s_hs(`URXF_HS_ACK);
   endproperty
   a_out_ack: assert property (p_out_ack) else $error("good out not acked");
   property p_out_nak;
      good_out && (!rcv_input_enable || ferr || !room) |=> s_hs(`URXF_HS_NAK);
   endproperty
   a_out_nak: assert property (p_out_nak) else $error("out not naked");
   property p_bad_nohs;
      open_q && bad |=> !hs_valid_q [*2];
   endproperty
   a_bad_nohs: assert property (p_bad_nohs) else $error("handshake on bad data");
   property p_bad_rewind;
      open_q && bad |=> wr_rewind_q && !wr_advance_q;
   endproperty
   a_bad_rewind: assert property (p_bad_rewind) else $error("bad data not rewound");
   property p_setup_adv;
      open_q && kind_q && data_good && !bad |=> wr_advance_q && !wr_rewind_q;
   endproperty
   a_setup_adv: assert property (p_setup_adv) else $error("setup marker not advanced");
   property p_ovf_sticky;
      rcv_overrun_flag && !flag_clear[4] && quiet |=> rcv_overrun_flag;
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("overrun flag lost");
   property p_urf_set;
      cpu_read_underrun |=> rcv_underrun_flag && !rcv_irq_q && $stable(rcv_fill_state);
   endproperty
   a_urf_set: assert property (p_urf_set) else $error("underrun not flagged");
   property p_read_done;
      rcv_read_complete && rcv_fill_state != 2'h0 && quiet |=>
         $countones(rcv_fill_state) + 1 == $countones($past(rcv_fill_state))
         && $stable(rcv_error_flag) && $stable(rcv_acked_flag) && $stable(rcv_void_flag);
   endproperty
   a_read_done: assert property (p_read_done) else $error("read complete wrong");
   property p_disabled;
      (out_token || setup_token) && !en && !open_q |=> !fifo_reset_q ##1 !hs_valid_q;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled endpoint acted");
endmodule // urxf_flow_checker

bind urxf_flow urxf_flow_checker chk (.clk, .rst_n, .rcv_endpoint_enable, .auto_rcv_manage,
   .single_packet_select, .rcv_input_enable, .rcv_stall, .out_token, .setup_token,
   .data_good, .data_crc_err, .data_timeout, .fifo_overrun, .hs_done, .hs_valid_q,
   .fifo_reset_q, .hs_code_q, .wr_advance_q, .wr_rewind_q,
   .cpu_read_underrun, .rcv_read_complete, .rcv_error_flag,
   .rcv_acked_flag, .rcv_void_flag, .rcv_overrun_flag, .rcv_underrun_flag, .rcv_irq_q,
   .setup_overwrite_end, .setup_overwrite_start_q, .flag_clear, .rcv_fill_state);

//--- bench/urxf_sie_model.sv
// Behavioural serial engine model: one token, one end event, then the handshake phase if a handshake was requested
module urxf_sie_model (
   // Clock and handshake request
   input wire logic clk,
   input wire logic hs_valid_q,
   input wire logic [1:0] hs_code_q,
   // Events towards the block
   output logic out_token, setup_token, data_good, data_crc_err,
   output logic data_timeout, fifo_overrun, toggle_mismatch, hs_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] hs_seen;
   initial begin
      {out_token, setup_token, data_good, data_crc_err} = 4'h0;
      {data_timeout, fifo_overrun, toggle_mismatch, hs_done} = 4'h0;
      hs_seen = 3'h4;
   end
   // Event code: 0 good, 1 crc, 2 time-out, 3 overrun, 4 toggle mismatch
   task automatic xfer(input logic setup, input logic [2:0] ev, input int slow);
      int i;
      hs_seen = 3'h4;
      @(negedge clk);
      out_token = ~setup;
      setup_token = setup;
      @(negedge clk);
      {out_token, setup_token} = 2'h0;
      repeat (slow) @(negedge clk);
      data_good = (ev == 3'h0) | (ev == 3'h4);
      data_crc_err = (ev == 3'h1);
      data_timeout = (ev == 3'h2);
      fifo_overrun = (ev == 3'h3);
      toggle_mismatch = (ev == 3'h4);
      @(negedge clk);
      {data_good, data_crc_err, data_timeout, fifo_overrun, toggle_mismatch} = 5'h00;
      for (i = 0; i < 3 && hs_seen == 3'h4; i++) begin
         if (hs_valid_q === 1'b1) hs_seen = {1'b0, hs_code_q};
         else @(negedge clk);
      end
      // The handshake phase closes only after a handshake was requested
      if (hs_seen != 3'h4) begin
         repeat (slow + 1) @(negedge clk);
         hs_done = 1'b1;
         @(negedge clk);
         hs_done = 1'b0;
      end
      repeat (3) @(negedge clk);
   endtask
endmodule // urxf_sie_model

//--- bench/urxf_flow_bench.sv
// Self-checking bench for the receive endpoint flow control block
module urxf_flow_bench;
   timeunit 1ns;
   timeprecision 1ns;
   `define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp); end end
   typedef struct packed {
      logic [4:0] cfg;
      logic [2:0] ev, hs;
      logic [6:0] fl;
      logic [1:0] fi;
      logic iq;
   } urxf_row_t;
   logic clk, rst_n, ep_en, sp, ie, stl, ctl, cpu_urf, rd_done, irq;
   logic out_tok, setup_tok, d_good, d_crc, d_tmo, d_ovf, tgl, hs_done, hs_valid;
   logic [6:0] clr, flags;
   logic [1:0] hs_code, fill;
   int err_total = 0, num_checks = 0, irq_cnt = 0, irq0, r;
   // Config bits: single, control, input enable, stall, setup token
   urxf_row_t rows [13] = '{
      '{5'h1C, 3'h0, 3'h0, 7'h02, 2'h1, 1'h1}, '{5'h0C, 3'h0, 3'h0, 7'h02, 2'h1, 1'h1},
      '{5'h1C, 3'h1, 3'h4, 7'h01, 2'h0, 1'h1}, '{5'h1C, 3'h3, 3'h4, 7'h11, 2'h0, 1'h1},
      '{5'h18, 3'h0, 3'h1, 7'h04, 2'h0, 1'h0}, '{5'h1C, 3'h2, 3'h4, 7'h04, 2'h0, 1'h0},
      '{5'h1C, 3'h4, 3'h0, 7'h00, 2'h0, 1'h0}, '{5'h1B, 3'h0, 3'h0, 7'h4A, 2'h1, 1'h1},
      '{5'h1D, 3'h2, 3'h4, 7'h01, 2'h0, 1'h1}, '{5'h1D, 3'h1, 3'h4, 7'h09, 2'h0, 1'h1},
      '{5'h1D, 3'h3, 3'h4, 7'h19, 2'h0, 1'h1}, '{5'h15, 3'h0, 3'h0, 7'h42, 2'h1, 1'h1},
      '{5'h0D, 3'h0, 3'h0, 7'h4A, 2'h1, 1'h1}};

   urxf_sie_model sie (.clk(clk), .hs_valid_q(hs_valid), .hs_code_q(hs_code),
      .out_token(out_tok), .setup_token(setup_tok), .data_good(d_good), .data_crc_err(d_crc),
      .data_timeout(d_tmo), .fifo_overrun(d_ovf), .toggle_mismatch(tgl), .hs_done(hs_done));
   urxf_flow dut (.clk(clk), .rst_n(rst_n), .rcv_endpoint_enable(ep_en), .auto_rcv_manage(1'b1),
      .single_packet_select(sp), .rcv_input_enable(ie), .rcv_stall(stl), .ctrl_endpoint(ctl),
      .out_token(out_tok), .setup_token(setup_tok), .data_good(d_good), .data_crc_err(d_crc),
      .data_timeout(d_tmo), .fifo_overrun(d_ovf), .toggle_mismatch(tgl), .hs_done(hs_done),
      .hs_valid_q(hs_valid), .hs_code_q(hs_code), .wr_advance_q(), .wr_rewind_q(),
      .fifo_reset_q(), .cpu_read_underrun(cpu_urf), .rcv_read_complete(rd_done),
      .flag_clear(clr), .rcv_error_flag(flags[0]), .rcv_acked_flag(flags[1]),
      .rcv_void_flag(flags[2]), .setup_received_flag(flags[3]), .rcv_overrun_flag(flags[4]),
      .rcv_underrun_flag(flags[5]), .setup_overwrite_end(flags[6]),
      .setup_overwrite_start_q(), .rcv_fill_state(fill), .rcv_irq_q(irq));

   // ****************************************
   // Clock, interrupt count and tasks
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (irq === 1'b1) irq_cnt++;
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic run(input logic setup, input logic [2:0] ev, input int slow);
      irq0 = irq_cnt;
      sie.xfer(setup, ev, slow);
   endtask
   task automatic expect_st(input logic [2:0] hs, input logic [6:0] fl, input logic [1:0] fi,
      input int iq);
      `CHK(sie.hs_seen, hs, "handshake")
      `CHK(flags, fl, "flags")
      `CHK(fill, fi, "fill state")
      `CHK(irq_cnt - irq0, iq, "interrupts")
   endtask
   task automatic fw(input logic u, input logic d, input logic [6:0] c);
      irq0 = irq_cnt;
      @(negedge clk);
      {cpu_urf, rd_done, clr} = {u, d, c};
      @(negedge clk);
      {cpu_urf, rd_done, clr} = 9'h000;
      @(negedge clk);
   endtask
   task automatic do_reset(input string name);
      $display("test %s done, mismatches %0d", name, err_total);
      @(negedge clk);
      rst_n = 1'b0;
      @(negedge clk);
      rst_n = 1'b1;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {rst_n, ep_en, sp, ie, stl, ctl, cpu_urf, rd_done, clr} = 15'h3E00;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      for (r = 0; r < 13; r++) begin
         {sp, ctl, ie, stl} = rows[r].cfg[4:1];
         run(rows[r].cfg[0], rows[r].ev, r % 3);
         expect_st(rows[r].hs, rows[r].fl, rows[r].fi, rows[r].iq);
         do_reset("row");
      end
      {sp, ctl, ie, stl} = 4'hE;
      run(1'b0, 3'h0, 1);
      run(1'b0, 3'h0, 0);
      expect_st(3'h1, 7'h06, 2'h1, 0);
      fw(1'b1, 1'b0, 7'h00);
      expect_st(3'h1, 7'h26, 2'h1, 0);
      run(1'b0, 3'h0, 0);
      expect_st(3'h1, 7'h26, 2'h1, 0);
      fw(1'b0, 1'b1, 7'h00);
      expect_st(3'h1, 7'h26, 2'h0, 0);
      run(1'b1, 3'h0, 2);
      expect_st(3'h0, 7'h4A, 2'h1, 1);
      do_reset("single");
      sp = 1'b0;
      run(1'b0, 3'h0, 0);
      run(1'b0, 3'h0, 1);
      expect_st(3'h0, 7'h02, 2'h3, 1);
      run(1'b0, 3'h0, 0);
      expect_st(3'h1, 7'h06, 2'h3, 0);
      fw(1'b0, 1'b1, 7'h00);
      expect_st(3'h1, 7'h06, 2'h2, 0);
      do_reset("dual");
      sp = 1'b1;
      run(1'b0, 3'h3, 0);
      run(1'b0, 3'h0, 1);
      expect_st(3'h1, 7'h15, 2'h0, 0);
      fw(1'b0, 1'b0, 7'h01);
      expect_st(3'h1, 7'h14, 2'h0, 0);
      run(1'b1, 3'h0, 0);
      expect_st(3'h0, 7'h4A, 2'h1, 1);
      fw(1'b0, 1'b0, 7'h7F);
      expect_st(3'h0, 7'h00, 2'h1, 0);
      do_reset("overrun");
      ep_en = 1'b0;
      run(1'b0, 3'h0, 0);
      run(1'b1, 3'h0, 0);
      expect_st(3'h4, 7'h00, 2'h0, 0);
      do_reset("disabled");
      stop_test();
   end
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      stop_test();
   end
endmodule // urxf_flow_bench
